// ---- hw/kfm_defs.vh ----
`ifndef KFM_DEFS_VH
`define KFM_DEFS_VH
// ==========================================================
// Register offsets (byte addresses)
`define KFM_REG_CTRL 8'h00
`define KFM_REG_CFG 8'h04
`define KFM_REG_PAD 8'h08
`define KFM_REG_STATUS 8'h0c
`define KFM_REG_FRAMES 8'h10
// ==========================================================
// Control fields
`define KFM_CTRL_START 0
`define KFM_CTRL_ABORT 1
// ==========================================================
// Configuration fields and reset value
`define KFM_CFG_J_LSB 0
`define KFM_CFG_J_MSB 9
`define KFM_CFG_DBL 10
`define KFM_CFG_CT 11
`define KFM_CFG_FMT_LSB 12
`define KFM_CFG_FMT_MSB 14
`define KFM_CFG_R_LSB 16
`define KFM_CFG_R_MSB 24
`define KFM_CFG_RESET 32'h0000_0050
// ==========================================================
// Status fields
`define KFM_ST_BUSY 0
`define KFM_ST_SEG 1
`define KFM_ST_ERR 2
`define KFM_ST_IDX_LSB 16
// ==========================================================
// B-field formats
`define KFM_FMT_UNPROT 3'h0
`define KFM_FMT_MULTI 3'h1
`define KFM_FMT_ETYPE 3'h2
`define KFM_FMT_SINGLE 3'h3
`define KFM_FMT_ENCOD 3'h4
// ==========================================================
// Segment bit classes
`define KFM_CL_DISC 2'h0
`define KFM_CL_MASK 2'h1
`define KFM_CL_PASS 2'h2
// ==========================================================
// Field geometry
`define KFM_TAIL_BITS 11'h028
`define KFM_DBL_J 10'h320
`define KFM_SUB_LEN 7'h50
`define KFM_SUB_DATA 7'h40
`define KFM_SUB_DATA_B 11'h040
`define KFM_SUB_LEN_B 11'h050
`define KFM_SINGLE_DATA 11'h300
`endif

// ---- hw/kfm_fifo.v ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// FIFO with a registered output stage
module kfm_fifo #(
    parameter WIDTH = 3,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output reg out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] cnt;
    wire push;
    wire pop;

    // Full stops the writer, the output register drains the array
    assign in_ready_o = (cnt != DEPTH[AW:0]);
    assign push = in_valid_i && in_ready_o;
    assign pop = (cnt != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);

    // Array write, no reset needed for storage
    always @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers, level and output stage
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
                out_data_o <= mem[rd_ptr];
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
            if (push && !pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule // kfm_fifo
`default_nettype wire

// ---- hw/kfm_mapper.v ----
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "kfm_defs.vh"
// ==========================================================
// Functional notes
// RULE_01: Half/long segments are 40+j bits each
// RULE_02: Control tail: segment 0..39 masks a8..a47
// RULE_03: Other tail: segment 0..39 consumed, dropped
// RULE_04: Unprotected: segment 40+i masks b(i)
// RULE_05: Multisubfield: 64 masked, 16 check unused
// RULE_06: j above 80: segment 120+ masks b80+
// RULE_07: E-type mux handled as multisubfield
// RULE_08: Padding passes clear, segment bits consumed
// RULE_09: Encoded: first j*r bits masked, rest dropped
// RULE_10: Half/long frame streams 80+2j bits
// RULE_11: Double slot segments are 840 bits
// RULE_12: Double unprotected: 800 bits masked
// RULE_13: Double single: 768 masked, 32 unused
// RULE_14: Double multi: ten 64/16 subfields
// RULE_15: Double encoded: first 800*r bits masked
// RULE_16: Double slot frame streams 1680 bits
// RULE_17: No segment bits for header, X-field
// RULE_18: Half/long subfield 64 data, 16 check
// RULE_19: Burst parameters loaded before frame start
module kfm_mapper #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire ks_bit_i,
    input wire ks_valid_i,
    output reg ks_ready_o,
    input wire fld_bit_i,
    input wire fld_valid_i,
    output reg fld_ready_o,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire out_bit_o,
    output wire out_tail_o,
    output wire out_seg_o,
    output reg busy_o
);
    // ==========================================================
    // Classification of one segment bit
    // Decides whether a segment bit masks a field bit, rides beside
    // a field bit that goes clear, or is consumed with no field bit.
    function [1:0] kfm_class;
        input [10:0] idx;
        input [6:0] sub;
        input dbl;
        input ct;
        input [2:0] fmt;
        input [9:0] j;
        input [9:0] pad;
        input [9:0] enc_n;
        reg [10:0] b;
        begin
            b = idx - `KFM_TAIL_BITS;
            kfm_class = `KFM_CL_DISC;
            if (idx < `KFM_TAIL_BITS) begin
                // Header and check bits never reach here at all
                kfm_class = ct ? `KFM_CL_MASK : `KFM_CL_DISC; // RULE_02 RULE_03 RULE_17
            end else begin
                case (fmt)
                    `KFM_FMT_UNPROT: begin
                        kfm_class = `KFM_CL_MASK; // RULE_04 RULE_12
                    end
                    `KFM_FMT_MULTI, `KFM_FMT_ETYPE: begin // RULE_07
                        if (dbl) begin
                            kfm_class = (sub < `KFM_SUB_DATA) ? `KFM_CL_MASK
                                                              : `KFM_CL_PASS; // RULE_14
                        end else if (b < `KFM_SUB_DATA_B) begin
                            kfm_class = `KFM_CL_MASK; // RULE_05 RULE_18
                        end else if (b < `KFM_SUB_LEN_B) begin
                            kfm_class = `KFM_CL_PASS; // RULE_05 RULE_18
                        end else if (b >= {1'b0, j - pad}) begin
                            kfm_class = `KFM_CL_PASS; // RULE_08
                        end else begin
                            kfm_class = `KFM_CL_MASK; // RULE_06
                        end
                    end
                    `KFM_FMT_SINGLE: begin
                        kfm_class = (b < `KFM_SINGLE_DATA) ? `KFM_CL_MASK
                                                           : `KFM_CL_PASS; // RULE_13
                    end
                    `KFM_FMT_ENCOD: begin
                        kfm_class = (b < {1'b0, enc_n}) ? `KFM_CL_MASK
                                                        : `KFM_CL_DISC; // RULE_09 RULE_15
                    end
                    default: begin
                        kfm_class = `KFM_CL_DISC;
                    end
                endcase
            end
        end
    endfunction

    // ==========================================================
    // Registers and state
    reg [31:0] cfg;
    reg [9:0] pad_len;
    reg [15:0] frames;
    reg cfg_err;
    reg [10:0] idx;
    reg [6:0] sub;
    reg seg;
    reg [1:0] cur_cls;
    reg ks_have;
    reg ks_r;
    reg fld_have;
    reg fld_r;
    reg [10:0] next_idx;
    reg [6:0] next_sub;
    reg next_seg;
    reg next_busy;
    reg [1:0] next_cls;
    reg next_ks_have;
    reg next_fld_have;
    reg [31:0] next_rdata;

    wire [9:0] cfg_j;
    wire cfg_dbl;
    wire cfg_ct;
    wire [2:0] cfg_fmt;
    wire [8:0] cfg_r;
    wire [9:0] j_eff;
    wire [10:0] seg_len;
    wire [18:0] enc_prod;
    wire [9:0] enc_n;
    wire cfg_bad;
    wire start_req;
    wire abort_req;
    wire need_fld;
    wire step;
    wire last_bit;
    wire fifo_ready;
    wire ks_take;
    wire fld_take;
    wire out_bit;

    // Configuration fields, latched copy is not kept: writes are blocked while busy
    assign cfg_j = cfg[`KFM_CFG_J_MSB:`KFM_CFG_J_LSB];
    assign cfg_dbl = cfg[`KFM_CFG_DBL];
    assign cfg_ct = cfg[`KFM_CFG_CT];
    assign cfg_fmt = cfg[`KFM_CFG_FMT_MSB:`KFM_CFG_FMT_LSB];
    assign cfg_r = cfg[`KFM_CFG_R_MSB:`KFM_CFG_R_LSB];

    // Segment length follows slot type
    assign j_eff = cfg_dbl ? `KFM_DBL_J : cfg_j; // RULE_11
    assign seg_len = {1'b0, j_eff} + `KFM_TAIL_BITS; // RULE_01 RULE_11

    // Codec ratio is a fraction in 1/256 steps, so j*r is truncated
    assign enc_prod = j_eff * cfg_r;
    assign enc_n = enc_prod[17:8];

    // Single subfield exists only on the double slot
    assign cfg_bad = (cfg_fmt > `KFM_FMT_ENCOD)
                     || (!cfg_dbl && cfg_fmt == `KFM_FMT_SINGLE)
                     || (!cfg_dbl && cfg_j == 10'h000);

    // Register strobes
    assign start_req = reg_wr_i && (reg_addr_i == `KFM_REG_CTRL)
                       && reg_wdata_i[`KFM_CTRL_START]; // RULE_19
    assign abort_req = reg_wr_i && (reg_addr_i == `KFM_REG_CTRL)
                       && reg_wdata_i[`KFM_CTRL_ABORT];

    // ==========================================================
    // Stepping one segment bit
    // A step needs the segment bit, and a field bit when the class asks
    // for one; the output FIFO stalls only those steps when full.
    assign need_fld = (cur_cls != `KFM_CL_DISC);
    assign step = busy_o && ks_have && (!need_fld || fld_have)
                  && (!need_fld || fifo_ready) && !abort_req;
    assign last_bit = (idx == seg_len - 11'h001);
    assign ks_take = ks_valid_i && ks_ready_o;
    assign fld_take = fld_valid_i && fld_ready_o;
    assign out_bit = (cur_cls == `KFM_CL_MASK) ? (fld_r ^ ks_r) : fld_r; // RULE_08

    // Next index, segment and class
    always @* begin
        next_idx = idx;
        next_sub = sub;
        next_seg = seg;
        next_busy = busy_o;
        next_cls = cur_cls;
        if (abort_req) begin
            next_busy = 1'b0;
        end else if (!busy_o && start_req && !cfg_bad) begin
            next_idx = 11'h000;
            next_sub = 7'h00;
            next_seg = 1'b0;
            next_busy = 1'b1;
            next_cls = kfm_class(11'h000, 7'h00, cfg_dbl, cfg_ct, cfg_fmt,
                                 j_eff, pad_len, enc_n);
        end else if (step) begin
            if (last_bit) begin
                // Second segment closes the frame: 80+2j or 1680 bits in all
                next_idx = 11'h000;
                next_sub = 7'h00;
                next_seg = ~seg; // RULE_10 RULE_16
                next_busy = ~seg;
            end else begin
                next_idx = idx + 11'h001;
                if (idx < `KFM_TAIL_BITS) begin
                    next_sub = 7'h00;
                end else begin
                    next_sub = (sub == `KFM_SUB_LEN - 7'h01) ? 7'h00 : sub + 7'h01;
                end
            end
            next_cls = kfm_class(next_idx, next_sub, cfg_dbl, cfg_ct, cfg_fmt,
                                 j_eff, pad_len, enc_n);
        end
    end

    // Holding flags for the two input streams
    always @* begin
        next_ks_have = ks_have ? !step : ks_take;
        next_fld_have = fld_have ? !(step && need_fld) : fld_take;
        if (abort_req) begin
            next_ks_have = 1'b0;
            next_fld_have = 1'b0;
        end
    end

    // ==========================================================
    // Sequencer registers
    // Readies are registered, so each stream moves at most one bit every
    // second cycle; this trades rate for flop-driven handshakes.
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idx <= 11'h000;
            sub <= 7'h00;
            seg <= 1'b0;
            busy_o <= 1'b0;
            cur_cls <= `KFM_CL_DISC;
            ks_have <= 1'b0;
            ks_r <= 1'b0;
            fld_have <= 1'b0;
            fld_r <= 1'b0;
            ks_ready_o <= 1'b0;
            fld_ready_o <= 1'b0;
        end else begin
            idx <= next_idx;
            sub <= next_sub;
            seg <= next_seg;
            busy_o <= next_busy;
            cur_cls <= next_cls;
            ks_have <= next_ks_have;
            fld_have <= next_fld_have;
            if (ks_take) begin
                ks_r <= ks_bit_i;
            end
            if (fld_take) begin
                fld_r <= fld_bit_i;
            end
            // Every segment bit is drawn, used or not
            ks_ready_o <= next_busy && !next_ks_have; // RULE_01 RULE_11
            // Field bits are drawn only where a tail or B-field bit exists
            fld_ready_o <= next_busy && !next_fld_have
                           && (next_cls != `KFM_CL_DISC); // RULE_17
        end
    end

    // ==========================================================
    // Register file
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg <= `KFM_CFG_RESET;
            pad_len <= 10'h000;
            frames <= 16'h0000;
            cfg_err <= 1'b0;
        end else begin
            // Burst parameters cannot change under a running frame
            if (reg_wr_i && !busy_o && reg_addr_i == `KFM_REG_CFG) begin
                cfg <= reg_wdata_i; // RULE_19
            end
            if (reg_wr_i && !busy_o && reg_addr_i == `KFM_REG_PAD) begin
                pad_len <= reg_wdata_i[9:0];
            end
            if (!busy_o && start_req) begin
                cfg_err <= cfg_bad;
            end
            if (step && last_bit && seg) begin
                frames <= frames + 16'h0001;
            end
        end
    end

    // Read data stands for one cycle only
    always @* begin
        next_rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `KFM_REG_CFG: begin
                    next_rdata = cfg;
                end
                `KFM_REG_PAD: begin
                    next_rdata = {22'h0, pad_len};
                end
                `KFM_REG_STATUS: begin
                    next_rdata = {5'h00, idx, 13'h0, cfg_err, seg, busy_o};
                end
                `KFM_REG_FRAMES: begin
                    next_rdata = {16'h0000, frames};
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ==========================================================
    // Output FIFO: mapped bit, tail flag, segment number
    kfm_fifo #(
        .WIDTH(3),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_valid_i(step && need_fld),
        .in_ready_o(fifo_ready),
        .in_data_i({seg, (idx < `KFM_TAIL_BITS), out_bit}),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o({out_seg_o, out_tail_o, out_bit_o})
    );
endmodule // kfm_mapper
`default_nettype wire

// ---- sim/kfm_mapper_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "kfm_defs.vh"
// ====================
// Bench for the keystream field mapper
module kfm_mapper_tb;
    logic clk_sys_i, nrst_i, reg_wr_i, reg_rd_i, out_ready_i, slow;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rd;
    logic ks_bit_i, ks_valid_i, ks_ready_o, fld_bit_i, fld_valid_i, fld_ready_o;
    logic out_valid_o, out_bit_o, out_tail_o, out_seg_o, busy_o;
    logic [15:0] ks_cnt, fld_cnt;
    logic [2:0] q[$];
    integer error_cnt, total_checks, frames;

    kfm_mapper u_kfm_mapper (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .ks_bit_i, .ks_valid_i, .ks_ready_o, .fld_bit_i, .fld_valid_i,
        .fld_ready_o, .out_valid_o, .out_ready_i, .out_bit_o, .out_tail_o, .out_seg_o, .busy_o);
    kfm_partner u_kfm_partner (.clk_sys_i, .nrst_i, .slow_i(slow), .ks_ready_i(ks_ready_o),
        .fld_ready_i(fld_ready_o), .ks_bit_o(ks_bit_i), .ks_valid_o(ks_valid_i),
        .fld_bit_o(fld_bit_i), .fld_valid_o(fld_valid_i), .ks_cnt_o(ks_cnt), .fld_cnt_o(fld_cnt));

    // 100 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Collect every accepted output bit
    always @(posedge clk_sys_i) begin
        if (out_valid_o && out_ready_i) q.push_back({out_tail_o, out_seg_o, out_bit_o});
    end

    // ====================
    // Shared tasks
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A gap cycle after each strobe keeps every strobe one cycle long
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        d = reg_rdata_o;
    endtask
    // Expected class of one segment position: 0 dropped, 1 masked, 2 clear
    function automatic logic [1:0] cls(input integer x, input integer b,
        input logic [31:0] cfg, input integer j, input integer pad, input integer enc);
        if (x < 40) return cfg[`KFM_CFG_CT] ? 2'h1 : 2'h0;
        case (cfg[`KFM_CFG_FMT_MSB:`KFM_CFG_FMT_LSB])
            `KFM_FMT_UNPROT: return 2'h1;
            `KFM_FMT_SINGLE: return b < 768 ? 2'h1 : 2'h2;
            `KFM_FMT_ENCOD: return b < enc ? 2'h1 : 2'h0;
            default: ;
        endcase
        if (cfg[`KFM_CFG_DBL]) return b % 80 < 64 ? 2'h1 : 2'h2;
        return (b >= 64 && b < 80) || b >= j - pad ? 2'h2 : 2'h1;
    endfunction
    // One whole frame, optionally with a slow source and a stalled sink
    task automatic run_frame(input logic [31:0] cfg, input integer pad, input logic slw,
        input logic stl);
        integer i, m, c, j, len, bad;
        logic [1:0] cl;
        logic [2:0] e;
        logic [15:0] k0, f0;
        slow <= slw;
        out_ready_i <= !stl;
        reg_write(`KFM_REG_PAD, pad);
        reg_write(`KFM_REG_CFG, cfg);
        q.delete();
        k0 = ks_cnt;
        f0 = fld_cnt;
        reg_write(`KFM_REG_CTRL, 32'h1);
        for (c = 0; c < 30000 && busy_o !== 1'b0; c++) begin
            @(posedge clk_sys_i);
            if (c == 200) out_ready_i <= 1'b1; // Stall long enough to fill the FIFO
        end
        if (c == 30000) begin
            check(c, 0);
            complete_run();
        end
        for (c = 0; c < 6 || (c < 50 && out_valid_o !== 1'b0); c++) @(posedge clk_sys_i);
        j = cfg[`KFM_CFG_DBL] ? 800 : cfg[9:0];
        len = 40 + j;
        m = 0;
        bad = 0;
        for (i = 0; i < 2 * len; i++) begin
            cl = cls(i % len, i % len - 40, cfg, j, pad, j * cfg[24:16] / 256);
            if (cl != 2'h0) begin
                e = {i % len < 40, i >= len, u_kfm_partner.pat(16'(f0 + m) ^ 16'h0f0f)
                    ^ (cl == 2'h1 && u_kfm_partner.pat(16'(k0 + i)))};
                if (bad == 0) check({29'h0, q[m]}, {29'h0, e});
                if (q[m] !== e) bad = 1;
                m++;
            end
        end
        check(q.size(), m);
        check({16'h0, ks_cnt - k0}, 2 * len);
        check({16'h0, fld_cnt - f0}, m);
        frames++;
    endtask

    // ====================
    // Scenarios
    task sc_regs;
        reg_read(`KFM_REG_CFG, rd);
        check(rd, `KFM_CFG_RESET);
        reg_read(8'h14, rd);
        check(rd, 32'h0);
        reg_write(`KFM_REG_CFG, 32'h0000_3050);
        reg_write(`KFM_REG_CTRL, 32'h1);
        reg_read(`KFM_REG_STATUS, rd);
        check({29'h0, rd[2:0]}, 32'h4);
    endtask
    task sc_half;
        run_frame(32'h0000_0850, 0, 1'b0, 1'b0);
        run_frame(32'h0000_0050, 0, 1'b1, 1'b1);
    endtask
    task sc_multi;
        run_frame(32'h0000_18a0, 0, 1'b0, 1'b0);
        run_frame(32'h0000_22a0, 16, 1'b1, 1'b0);
    endtask
    task sc_encoded;
        run_frame(32'h0080_4850, 0, 1'b0, 1'b0);
        run_frame(32'h00c0_4400, 0, 1'b0, 1'b0);
    endtask
    task sc_double;
        run_frame(32'h0000_0c00, 0, 1'b0, 1'b0);
        run_frame(32'h0000_3400, 0, 1'b0, 1'b0);
        run_frame(32'h0000_1c00, 0, 1'b0, 1'b0);
        run_frame(32'h0000_2c00, 0, 1'b0, 1'b1);
    endtask
    task sc_busy;
        reg_write(`KFM_REG_CFG, 32'h0000_0c00);
        reg_write(`KFM_REG_CTRL, 32'h1);
        reg_write(`KFM_REG_CFG, 32'h0000_0050);
        reg_read(`KFM_REG_CFG, rd);
        check(rd, 32'h0000_0c00);
        reg_read(`KFM_REG_FRAMES, rd);
        check(rd, frames);
        reg_write(`KFM_REG_CTRL, 32'h2);
        reg_read(`KFM_REG_STATUS, rd);
        check({31'h0, rd[0]}, 32'h0);
    endtask

    // ====================
    // Main sequence
    initial begin
        error_cnt = 0;
        total_checks = 0;
        frames = 0;
        nrst_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        out_ready_i = 1'b0;
        slow = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        sc_regs();
        sc_half();
        sc_multi();
        sc_encoded();
        sc_double();
        sc_busy();
        complete_run();
    end
endmodule // kfm_mapper_tb
`default_nettype wire

// ---- sim/kfm_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port checker for the mapper top
module kfm_monitor (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic ks_valid_i,
    input wire logic ks_ready_o,
    input wire logic fld_valid_i,
    input wire logic fld_ready_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic out_bit_o,
    input wire logic out_tail_o,
    input wire logic out_seg_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Register answers and frame start
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");
    start_cause_a: assert property ($rose(busy_o) |->
        $past(reg_wr_i) && $past(reg_addr_i) == 8'h00 && $past(reg_wdata_i[0]))
        else $error("frame started without a start write");
    start_ready_a: assert property ($rose(busy_o) |-> ks_ready_o)
        else $error("keystream not requested at frame start");
    // One bit per take; no keystream bit taken outside a frame
    ks_take_a: assert property (ks_valid_i && ks_ready_o |=> !ks_ready_o)
        else $error("keystream ready held after take");
    fld_take_a: assert property (fld_valid_i && fld_ready_o |=> !fld_ready_o)
        else $error("field ready held after take");
    take_busy_a: assert property (ks_valid_i && ks_ready_o |-> busy_o)
        else $error("keystream taken while idle");
    // Output held while stalled; tail bits lead each segment
    out_hold_a: assert property (out_valid_o && !out_ready_i |=>
        out_valid_o && $stable({out_bit_o, out_tail_o, out_seg_o}))
        else $error("output changed while stalled");
    tail_first_a: assert property (out_valid_o && out_ready_i && !out_tail_o |=>
        !(out_valid_o && out_tail_o && out_seg_o == $past(out_seg_o)))
        else $error("tail bit after field bit");
    cover property ($rose(busy_o));
    cover property (out_valid_o && !out_ready_i);
    cover property (out_valid_o && out_ready_i && out_tail_o && out_seg_o);
endmodule // kfm_monitor

bind kfm_mapper kfm_monitor u_kfm_monitor (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ks_valid_i, .ks_ready_o, .fld_valid_i, .fld_ready_o,
    .out_valid_o, .out_ready_i, .out_bit_o, .out_tail_o, .out_seg_o, .busy_o);
`default_nettype wire

// ---- sim/kfm_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====================
// Keystream source and field source
module kfm_partner (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic slow_i,
    input wire logic ks_ready_i,
    input wire logic fld_ready_i,
    output logic ks_bit_o,
    output logic ks_valid_o,
    output logic fld_bit_o,
    output logic fld_valid_o,
    output logic [15:0] ks_cnt_o,
    output logic [15:0] fld_cnt_o
);
    logic [1:0] tick;
    // Pattern also used by the bench for expectations
    function automatic logic pat(input logic [15:0] x);
        pat = ^(x & 16'h04a7);
    endfunction
    // Keystream: one unbroken numbered run across both segments
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick <= 2'h0;
            ks_valid_o <= 1'b0;
            ks_bit_o <= 1'b0;
            ks_cnt_o <= 16'h0;
        end else begin
            tick <= tick + 2'h1;
            if (ks_valid_o && ks_ready_i) begin
                ks_valid_o <= 1'b0;
                ks_bit_o <= ~ks_bit_o; // Released line must not look valid
                ks_cnt_o <= ks_cnt_o + 16'h1;
            end else if (!ks_valid_o && (!slow_i || tick == 2'h0)) begin
                ks_valid_o <= 1'b1;
                ks_bit_o <= pat(ks_cnt_o);
            end
        end
    end
    // Field bits, offered whenever not already valid (in slow mode at tick 2 only); only positions that carry one take them
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fld_valid_o <= 1'b0;
            fld_bit_o <= 1'b0;
            fld_cnt_o <= 16'h0;
        end else if (fld_valid_o && fld_ready_i) begin
            fld_valid_o <= 1'b0;
            fld_bit_o <= ~fld_bit_o;
            fld_cnt_o <= fld_cnt_o + 16'h1;
        end else if (!fld_valid_o && (!slow_i || tick == 2'h2)) begin
            fld_valid_o <= 1'b1;
            fld_bit_o <= pat(fld_cnt_o ^ 16'h0f0f);
        end
    end
endmodule // kfm_partner
`default_nettype wire
